//--- twu_top.sv
// Overview of operation
// [RULE1] each falling edge of a timer's selected clock lowers its low counter by one.
// [RULE2] in prescaler mode timer one or two reloads its low counter from the low latch each pass.
// [RULE3] the watchdog has no prescaler mode and its low counter is always the lower count half.
// [RULE4] writing a low counter location only updates the low latch.
// [RULE5] reading a high or low counter location returns the running count.
// [RULE6] a falling edge with the low counter at zero lowers a nonzero high counter by one.
// [RULE7] a rising edge with the high count expired sets the interrupt flag of timer one, two or baud.
// [RULE8] a watchdog timeout drives the restart pin low for two slow clock cycles.
// [RULE9] every timeout reloads both counters from their latches.
// [RULE10] writing the high counter of timer one, two or baud loads its latch and both counters.
// [RULE11] the watchdog stays idle after reset until its load-enable bit first goes from 0 to 1.
// [RULE12] each 0 to 1 change of the load-enable bit reloads the watchdog; 1 to 0 does nothing.
// [RULE13] control bit 1 picks the slow clock (0) or fast clock (1) for the watchdog.
// [RULE14] a control bit picks processor clock or external input falling pulses for the baud timer.
// [RULE15] each timer is an 8-bit low and 8-bit high counter, each with its own 8-bit latch.
`timescale 1ns/100ps
`default_nettype none
module twu_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [twu_pkg::TWU_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [twu_pkg::TWU_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [twu_pkg::TWU_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic processor_clock_phase,
    input wire logic slow_clock_source,
    input wire logic fast_clock_source,
    input wire logic external_timer_input,
    output logic restart_pin_out,
    output logic restart_pin_oe,
    output logic irq
);
    import twu_pkg::*;

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        twu_bus_state_t bus;
        logic [31:0] rdata;
        logic [7:0] timer_control_one;
        logic [7:0] timer_control_two;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [3:0][7:0] lo;
        logic [3:0][7:0] hi;
        logic [3:0][7:0] lo_latch;
        logic [3:0][7:0] hi_latch;
        logic [3:0] pend;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] stable;
        logic wd_active;
        logic restart_active;
        logic [1:0] restart_cnt;
    } twu_state_t;

    twu_state_t st;
    twu_state_t next_st;

    // ******************************************************
    // clock source edges
    // ******************************************************
    logic [3:0] src_pins;
    logic [3:0] src_now;
    logic [3:0] src_fall;
    logic [3:0] src_rise;
    logic [3:0][1:0] tsel;
    logic [3:0] run;
    logic [3:0] prescale;
    logic [3:0] tfall;
    logic [3:0] trise;
    logic [5:0] idx;
    logic [1:0] tn;
    logic acc;
    logic [3:0][7:0] cnt_lo;
    logic [3:0][7:0] cnt_hi;
    logic [3:0] cnt_pend;
    logic [3:0] tmo;

    assign src_pins = {external_timer_input, fast_clock_source,
                       slow_clock_source, processor_clock_phase};

    // a change counts once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_src
            logic [7:0] lo_n;
            logic [7:0] hi_n;
            logic pend_n;
            logic tmo_n;
            assign src_now[g] = (st.sync2[g] == st.sync3[g]) ? st.sync3[g] : st.stable[g];
            assign src_fall[g] = st.stable[g] & ~src_now[g];
            assign src_rise[g] = ~st.stable[g] & src_now[g];
            assign tfall[g] = run[g] & src_fall[tsel[g]];
            assign trise[g] = run[g] & src_rise[tsel[g]];

            // one timer's count, before any software load takes over
            always_comb begin
                lo_n = st.lo[g];
                hi_n = st.hi[g];
                pend_n = st.pend[g];
                tmo_n = 1'b0;
                if (tfall[g]) begin
                    if (st.lo[g] == 8'h00) begin
                        if (prescale[g]) begin
                            lo_n = st.lo_latch[g]; // [RULE2]
                        end else begin
                            lo_n = TWU_COUNT_WRAP; // [RULE1]
                        end
                        if (st.hi[g] != 8'h00) begin
                            hi_n = st.hi[g] - 8'h01; // [RULE6]
                        end else begin
                            pend_n = 1'b1;
                        end
                    end else begin
                        lo_n = st.lo[g] - 8'h01; // [RULE1]
                    end
                end
                if (trise[g] && st.pend[g]) begin
                    tmo_n = 1'b1;
                    lo_n = st.lo_latch[g]; // [RULE9]
                    hi_n = st.hi_latch[g]; // [RULE9]
                    pend_n = 1'b0;
                end
            end

            assign cnt_lo[g] = lo_n;
            assign cnt_hi[g] = hi_n;
            assign cnt_pend[g] = pend_n;
            assign tmo[g] = tmo_n;
        end
    endgenerate

    assign tsel[TWU_TMR_ONE] = TWU_SRC_PROC;
    assign tsel[TWU_TMR_TWO] = TWU_SRC_PROC;
    assign tsel[TWU_TMR_BAUD] = st.timer_control_one[TWU_C1_BAUD_EXT] ? TWU_SRC_EXT
                                                                      : TWU_SRC_PROC; // [RULE14]
    assign tsel[TWU_TMR_WD] = st.timer_control_one[TWU_C1_WD_FAST] ? TWU_SRC_FAST
                                                                    : TWU_SRC_SLOW; // [RULE13]

    assign run[TWU_TMR_ONE] = st.timer_control_two[TWU_C2_T1_RUN];
    assign run[TWU_TMR_TWO] = st.timer_control_two[TWU_C2_T2_RUN];
    assign run[TWU_TMR_BAUD] = st.timer_control_one[TWU_C1_BAUD_RUN];
    assign run[TWU_TMR_WD] = st.wd_active; // [RULE11]

    assign prescale[TWU_TMR_ONE] = st.timer_control_two[TWU_C2_T1_PRESCALE];
    assign prescale[TWU_TMR_TWO] = st.timer_control_two[TWU_C2_T2_PRESCALE];
    assign prescale[TWU_TMR_BAUD] = 1'b0;
    assign prescale[TWU_TMR_WD] = 1'b0; // [RULE3]

    // ******************************************************
    // bus decode
    // ******************************************************
    assign idx = avs_address[7:2];
    assign tn = idx[2:1];
    assign acc = avs_read | avs_write;
    assign avs_waitrequest = acc & (st.bus != TWU_BUS_ACK);
    assign avs_readdata = st.rdata;
    assign irq = |(st.irq_status & st.irq_mask);
    assign restart_pin_out = 1'b0;
    assign restart_pin_oe = st.restart_active; // [RULE8]

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        logic [7:0] wdat;
        logic [7:0] rval;
        logic [7:0] clr;
        logic is_timer;
        logic do_write;
        wdat = avs_writedata[7:0];
        rval = 8'h00;
        clr = 8'h00;
        is_timer = (idx >= TWU_IDX_TIMER_BASE) && (idx <= TWU_IDX_TIMER_LAST);
        do_write = 1'b0;
        next_st = st;

        // ******************************************************
        // pin synchronisers
        // ******************************************************
        next_st.sync1 = src_pins;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.stable = src_now;

        // ******************************************************
        // counting, software loads below take over
        // ******************************************************
        next_st.lo = cnt_lo;
        next_st.hi = cnt_hi;
        next_st.pend = cnt_pend;

        // ******************************************************
        // watchdog restart pulse
        // ******************************************************
        if (st.restart_active && src_rise[TWU_SRC_SLOW]) begin
            next_st.restart_cnt = st.restart_cnt + 2'h1;
            if (st.restart_cnt + 2'h1 == TWU_RESTART_SLOW_CYCLES) begin
                next_st.restart_active = 1'b0; // [RULE8]
            end
        end
        if (tmo[TWU_TMR_WD]) begin
            next_st.restart_active = 1'b1; // [RULE8]
            next_st.restart_cnt = 2'h0;
        end

        // ******************************************************
        // read mux
        // ******************************************************
        if (is_timer) begin
            rval = idx[0] ? st.hi[tn] : st.lo[tn]; // [RULE5]
        end else begin
            unique case (idx)
                TWU_IDX_CTRL_ONE: rval = st.timer_control_one;
                TWU_IDX_CTRL_TWO: rval = st.timer_control_two;
                TWU_IDX_IRQ_STATUS: rval = st.irq_status;
                TWU_IDX_IRQ_MASK: rval = st.irq_mask;
                default: rval = 8'h00;
            endcase
        end

        // ******************************************************
        // bus handshake, one wait state
        // ******************************************************
        unique case (st.bus)
            TWU_BUS_IDLE: begin
                if (acc) begin
                    next_st.bus = TWU_BUS_ACK;
                end
                // read data keeps the last read value across writes
                if (avs_read) begin
                    next_st.rdata = {24'h000000, rval}; // [RULE5]
                end
            end
            TWU_BUS_ACK: begin
                next_st.bus = TWU_BUS_IDLE;
                do_write = avs_write & avs_byteenable[0];
            end
        endcase

        // ******************************************************
        // register writes
        // ******************************************************
        if (do_write) begin
            if (is_timer) begin
                if (!idx[0]) begin
                    next_st.lo_latch[tn] = wdat; // [RULE4]
                end else begin
                    next_st.hi_latch[tn] = wdat; // [RULE15]
                    if (tn != TWU_TMR_WD) begin
                        next_st.hi[tn] = wdat; // [RULE10]
                        next_st.lo[tn] = st.lo_latch[tn]; // [RULE10]
                        next_st.pend[tn] = 1'b0;
                    end
                end
            end else begin
                unique case (idx)
                    TWU_IDX_CTRL_ONE: begin
                        next_st.timer_control_one = wdat;
                        if (!st.timer_control_one[TWU_C1_WD_LOAD] && wdat[TWU_C1_WD_LOAD]) begin
                            next_st.wd_active = 1'b1; // [RULE11]
                            next_st.lo[TWU_TMR_WD] = st.lo_latch[TWU_TMR_WD]; // [RULE12]
                            next_st.hi[TWU_TMR_WD] = st.hi_latch[TWU_TMR_WD]; // [RULE12]
                            next_st.pend[TWU_TMR_WD] = 1'b0;
                        end
                    end
                    TWU_IDX_CTRL_TWO: next_st.timer_control_two = wdat;
                    TWU_IDX_IRQ_STATUS: clr = wdat;
                    TWU_IDX_IRQ_MASK: next_st.irq_mask = wdat;
                    default: clr = 8'h00;
                endcase
            end
        end

        // ******************************************************
        // sticky flags, a set in the clearing cycle wins
        // ******************************************************
        next_st.irq_status = (st.irq_status & ~clr) | {5'h00, tmo[2:0]}; // [RULE7]
    end

    // ******************************************************
    // registers
    // ******************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

//--- twu_pkg.sv
`default_nettype none
package twu_pkg;
    // ******************************************************
    // bus geometry
    // ******************************************************
    localparam int TWU_ADDR_W = 8;
    localparam int TWU_DATA_W = 32;

    // ******************************************************
    // register indices, byte address is four times the index
    // ******************************************************
    localparam logic [5:0] TWU_IDX_CTRL_ONE = 6'h0A;
    localparam logic [5:0] TWU_IDX_CTRL_TWO = 6'h0B;
    localparam logic [5:0] TWU_IDX_IRQ_STATUS = 6'h0C;
    localparam logic [5:0] TWU_IDX_IRQ_MASK = 6'h0D;
    localparam logic [5:0] TWU_IDX_TIMER_BASE = 6'h10;
    localparam logic [5:0] TWU_IDX_TIMER_LAST = 6'h17;

    // ******************************************************
    // timer_control_one fields
    // ******************************************************
    localparam int TWU_C1_WD_LOAD = 0;
    localparam int TWU_C1_WD_FAST = 1;
    localparam int TWU_C1_BAUD_RUN = 2;
    localparam int TWU_C1_BAUD_EXT = 3;

    // ******************************************************
    // timer_control_two fields
    // ******************************************************
    localparam int TWU_C2_T1_RUN = 0;
    localparam int TWU_C2_T2_RUN = 1;
    localparam int TWU_C2_T1_PRESCALE = 2;
    localparam int TWU_C2_T2_PRESCALE = 3;

    // ******************************************************
    // timer numbers and clock sources
    // ******************************************************
    localparam logic [1:0] TWU_TMR_ONE = 2'h0;
    localparam logic [1:0] TWU_TMR_TWO = 2'h1;
    localparam logic [1:0] TWU_TMR_BAUD = 2'h2;
    localparam logic [1:0] TWU_TMR_WD = 2'h3;
    localparam logic [1:0] TWU_SRC_PROC = 2'h0;
    localparam logic [1:0] TWU_SRC_SLOW = 2'h1;
    localparam logic [1:0] TWU_SRC_FAST = 2'h2;
    localparam logic [1:0] TWU_SRC_EXT = 2'h3;

    // ******************************************************
    // values after reset and counts
    // ******************************************************
    localparam logic [7:0] TWU_REG_RESET = 8'h00;
    localparam logic [7:0] TWU_COUNT_WRAP = 8'hFF;
    localparam logic [1:0] TWU_RESTART_SLOW_CYCLES = 2'h2;

    typedef enum logic [0:0] {
        TWU_BUS_IDLE = 1'b0,
        TWU_BUS_ACK = 1'b1
    } twu_bus_state_t;
endpackage
`default_nettype wire

//--- twu_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module twu_top_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [twu_pkg::TWU_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [twu_pkg::TWU_DATA_W-1:0] avs_writedata,
    input wire logic [twu_pkg::TWU_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic slow_clock_source,
    input wire logic restart_pin_out,
    input wire logic restart_pin_oe,
    input wire logic irq
);
    import twu_pkg::*;
    logic armed;
    logic [3:0] rises;
    wire logic done_w = avs_write && !avs_waitrequest;
    wire logic rd_done = avs_read && !avs_waitrequest;
    wire logic rd_wait = avs_read && avs_waitrequest;
    wire logic mask_clr = done_w && avs_address == 8'h34 && avs_writedata[2:0] == 3'h0;
    // rises counts raw slow clock rising edges while the restart pulse is out
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
            rises <= 4'h0;
        end else begin
            if (done_w && avs_address == 8'h28 && avs_writedata[0]) begin
                armed <= 1'b1;
            end
            rises <= !restart_pin_oe ? 4'h0 : rises + 4'($rose(slow_clock_source));
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without a wait state");
    ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    rdata_upper_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    rdata_hold_a: assert property (!rd_wait |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    quiet_start_a: assert property ($rose(arst_n) |-> !restart_pin_oe && !irq)
        else $error("outputs active after reset");
    pin_low_a: assert property (restart_pin_out == 1'b0)
        else $error("restart pin data not low");
    wd_idle_a: assert property (!armed |-> !restart_pin_oe)
        else $error("watchdog fired before first start");
    restart_len_a: assert property ($fell(restart_pin_oe) |-> rises == 4'h2)
        else $error("restart pulse not two slow cycles");
    irq_mask_a: assert property (mask_clr |=> !irq)
        else $error("irq high with all masked");
    cover property ($rose(restart_pin_oe));
    cover property ($rose(irq));
    cover property (avs_read && !avs_waitrequest);
endmodule
bind twu_top twu_top_sva u_sva (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .slow_clock_source(slow_clock_source), .restart_pin_out(restart_pin_out),
    .restart_pin_oe(restart_pin_oe), .irq(irq));
`default_nettype wire

//--- timer_watchdog_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module timer_watchdog_unit_test;
    import twu_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0, fast = 1'b0;
    logic proc = 1'b1, ext = 1'b1, slow_en = 1'b0, fast_en = 1'b0, wait_r, oe, pin, irq;
    logic [7:0] addr = 8'h00;
    logic [3:0] div = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    int fails = 0, comparisons = 0, lo[3], hi[3], llo[3], lhi[3], pre[3], flg, n;
    bit [31:0] seed = 32'h8AA6;
    bit bext = 1'b1;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        div <= div + 4'h1;
        if (slow_en && div[2:0] == 3'h7) slow <= ~slow;
        if (fast_en && div[0]) fast <= ~fast;
    end
    twu_top dut (.clk(clk), .arst_n(arst_n), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .processor_clock_phase(proc), .slow_clock_source(slow),
        .fast_clock_source(fast), .external_timer_input(ext), .restart_pin_out(pin),
        .restart_pin_oe(oe), .irq(irq));
    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        n = 0;
        // waitrequest and read data are seen as they stood at each rising edge
        do begin @(posedge clk); n++; end while (wait_r !== 1'b0 && n < 50);
        if (n >= 50) begin fails++; results(); end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input int e);
        bus(1'b0, a, 8'h00);
        `CHK(q, 32'(e))
    endtask
    task automatic wait_oe(input bit v);
        n = 0;
        while (oe !== v && n < 600) begin @(negedge clk); n++; end
        if (n >= 600) begin fails++; results(); end
    endtask
    // one falling then rising pulse on the selected timer pins, model follows
    task automatic pulse(input bit [1:0] m);
        @(posedge clk);
        proc <= !m[0];
        ext <= !m[1];
        repeat (6) @(posedge clk);
        proc <= 1'b1;
        ext <= 1'b1;
        repeat (6) @(posedge clk);
        for (int t = 0; t < 3; t++) begin
            if ((t < 2 || !bext) ? m[0] : m[1]) begin
                if (lo[t] != 0) lo[t]--;
                else begin
                    lo[t] = pre[t] ? llo[t] : 255;
                    if (hi[t] != 0) hi[t]--;
                    else begin lo[t] = llo[t]; hi[t] = lhi[t]; flg |= 1 << t; end
                end
            end
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 8'h28; a <= 8'h5C; a += 4) chk(8'(a), 0);
        bus(1'b1, 8'hFC, 8'hFF);
        chk(8'hFC, 0);
        pre = '{0, 1, 0};
        flg = 0;
        for (int t = 0; t < 3; t++) begin
            llo[t] = int'(rnd() & 3);
            lhi[t] = pre[t] ? int'(rnd() & 1) : 0;
            bus(1'b1, 8'(8'h40 + 8 * t), 8'(llo[t]));
            chk(8'(8'h40 + 8 * t), 0);
            bus(1'b1, 8'(8'h44 + 8 * t), 8'(lhi[t]));
            lo[t] = llo[t];
            hi[t] = lhi[t];
        end
        bus(1'b1, 8'h34, 8'h07);
        chk(8'h34, 7);
        bus(1'b1, 8'h2C, 8'h0B);
        bus(1'b1, 8'h28, 8'h0C);
        for (int k = 0; k < 40; k++) begin
            // late passes move the baud timer onto the processor clock
            if (k == 30) begin
                bus(1'b1, 8'h28, 8'h04);
                bext = 1'b0;
            end
            for (int t = 0; t < 3; t++) begin
                chk(8'(8'h40 + 8 * t), lo[t]);
                chk(8'(8'h44 + 8 * t), hi[t]);
            end
            chk(8'h30, flg);
            `CHK(irq, flg != 0)
            pulse(2'(rnd()));
        end
        bus(1'b1, 8'h34, 8'h00);
        @(negedge clk);
        `CHK(irq, 1'b0)
        bus(1'b1, 8'h30, 8'h07);
        chk(8'h30, 0);
        bus(1'b1, 8'h58, 8'h03);
        bus(1'b1, 8'h5C, 8'h00);
        chk(8'h58, 0);
        slow_en <= 1'b1;
        repeat (200) @(negedge clk);
        `CHK(oe, 1'b0)
        bus(1'b1, 8'h28, 8'h0D);
        wait_oe(1'b1);
        `CHK(pin, 1'b0)
        wait_oe(1'b0);
        bus(1'b1, 8'h28, 8'h0E);
        slow_en <= 1'b0;
        bus(1'b1, 8'h28, 8'h0F);
        fast_en <= 1'b1;
        wait_oe(1'b1);
        // back on the slow clock, or the fast watchdog keeps restarting the pulse
        bus(1'b1, 8'h28, 8'h0D);
        slow_en <= 1'b1;
        wait_oe(1'b0);
        results();
    end
endmodule
`default_nettype wire
